/* rtl/brc_pkg.sv */
// Shared constants and types for the burst read configuration block.
// Assumes both link ends and the bench import it whole.
package brc_pkg;

  // Configuration register field positions
  localparam int RS_BIT = 15;
  localparam int XL_HI  = 14;
  localparam int XL_LO  = 11;
  localparam int YL_BIT = 9;
  localparam int RT_BIT = 8;
  localparam int BO_BIT = 7;
  localparam int CK_BIT = 6;
  localparam int AT_BIT = 3;
  localparam int BL_HI  = 2;
  localparam int BL_LO  = 0;

  // Value after reset: asynchronous random read
  localparam logic [15:0] CFG_RESET = 16'h8000;

  // Burst length codes
  localparam logic [2:0] BL_1    = 3'h4;
  localparam logic [2:0] BL_2    = 3'h5;
  localparam logic [2:0] BL_4    = 3'h1;
  localparam logic [2:0] BL_8    = 3'h2;
  localparam logic [2:0] BL_CONT = 3'h7;

  // First-access latency codes
  localparam logic [3:0] XL_7  = 4'h2;
  localparam logic [3:0] XL_8  = 4'h3;
  localparam logic [3:0] XL_9  = 4'h4;
  localparam logic [3:0] XL_10 = 4'h5;
  localparam logic [3:0] XL_11 = 4'h6;
  localparam logic [3:0] XL_12 = 4'h9;
  localparam logic [3:0] XL_13 = 4'hA;
  localparam logic [3:0] XL_14 = 4'hB;
  localparam logic [3:0] XL_16 = 4'hC;

  // Next-access latency in valid edges
  localparam logic [1:0] YL_ONE = 2'h1;
  localparam logic [1:0] YL_TWO = 2'h2;

  // Extra wait edges for an unaligned continuous start
  localparam logic [4:0] UNALIGN_EDGES = 5'h04;

  // Host register map and control bits
  localparam logic [3:0] HR_CTRL  = 4'h0;
  localparam logic [3:0] HR_CFG   = 4'h1;
  localparam logic [3:0] HR_ADDR  = 4'h2;
  localparam logic [3:0] HR_NEXT  = 4'h3;
  localparam logic [3:0] HR_WORDS = 4'h4;
  localparam logic [3:0] HR_STAT  = 4'h5;
  localparam logic [3:0] HR_DATA  = 4'h6;
  localparam int HC_START = 0;
  localparam int HC_X32   = 1;
  localparam int HC_HOLD  = 2;
  localparam int HC_PIPE  = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DATA = 2'b10
  } brc_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ARM  = 2'b01,
    H_RUN  = 2'b10
  } brc_hstate_t;

  // Latency code to edges; reserved codes fall back to the slowest
  function automatic logic [4:0] brc_xlat(input logic [3:0] c);
    case (c)
      XL_7:    brc_xlat = 5'h07;
      XL_8:    brc_xlat = 5'h08;
      XL_9:    brc_xlat = 5'h09;
      XL_10:   brc_xlat = 5'h0A;
      XL_11:   brc_xlat = 5'h0B;
      XL_12:   brc_xlat = 5'h0C;
      XL_13:   brc_xlat = 5'h0D;
      XL_14:   brc_xlat = 5'h0E;
      default: brc_xlat = 5'h10;
    endcase
  endfunction

  // Length code to units; zero means continuous
  function automatic logic [3:0] brc_blen(input logic [2:0] c);
    case (c)
      BL_1:    brc_blen = 4'h1;
      BL_2:    brc_blen = 4'h2;
      BL_4:    brc_blen = 4'h4;
      BL_8:    brc_blen = 4'h8;
      default: brc_blen = 4'h0;
    endcase
  endfunction

endpackage

/* rtl/brc_if.sv */
// Link between the host burst controller and the flash read logic.
// Assumes one system clock; every pin is a plain synchronous level.
`timescale 1ns/10ps
interface brc_if #(
  parameter int AW = 22
);
  logic          burst_clk;
  logic          ce_n;
  logic          lat_n;
  logic          adv_n;
  logic [AW-1:0] addr;
  logic          word32;
  logic          cfg_we;
  logic [15:0]   cfg_data;
  logic [31:0]   rdata;
  logic          ready;

  modport dev (
    input  burst_clk, ce_n, lat_n, adv_n, addr, word32, cfg_we, cfg_data,
    output rdata, ready
  );

  modport host (
    output burst_clk, ce_n, lat_n, adv_n, addr, word32, cfg_we, cfg_data,
    input  rdata, ready
  );
endinterface

/* rtl/brc_device.sv */
// Flash read end: burst configuration register and read sequencer.
// Assumes the burst clock is a level sampled on clk_i and an array
// port that answers combinationally in the same cycle.
//
// Overview of operation
// - Read select bit: 0 burst, 1 asynchronous
// - First datum 7 to 16 edges after capture
// - Host uses latency 7 only for continuous
// - Latency field decodes to 7..14, plus 16
// - Next latency bit: one or two edges
// - Host picks latency by burst clock rate
// - Ready timing bit: now or one edge early
// - Ready output marks valid data at edge
// - Order bit: 0 interleaved, 1 sequential
// - Clock edge bit: 0 falling, 1 rising
// - Async type bit: random or latch controlled
// - Length field decodes 1,2,4,8 or continuous
// - Host limits continuous and eight-word bursts
// - Fixed bursts wrap inside their aligned block
// - Sequential adds, interleaved xors the offset
// - Unaligned continuous start adds wait edges
// - Host relatches six edges before last datum; brc_host relatches right after capture
// - Pipelining only for lengths four and eight
// - Ready low: no data, no address advance
// - Advance high suspends the burst output; brc_device still presents the first datum
// - Reset gives asynchronous random read mode
// - Continuous burst wraps to address zero
`timescale 1ns/10ps
module brc_device
  import brc_pkg::*;
#(
  parameter int AW = 22
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // Link to the host controller
  brc_if.dev                 lnk,
  // Array read port
  output logic [AW-1:0]      mem_addr_o,
  input  wire logic [31:0]   mem_rdata_i,
  // Configuration view
  output logic [15:0]        cfg_o
);

  logic [15:0]   cfg_q;
  logic          k_q;
  brc_state_t    st_q;
  brc_state_t    st_d;
  logic [AW-1:0] base_q;
  logic [AW-1:0] base_d;
  logic [AW-1:0] step_q;
  logic [AW-1:0] step_d;
  logic [4:0]    cnt_q;
  logic [4:0]    cnt_d;
  logic [4:0]    tgt_q;
  logic [4:0]    tgt_d;
  logic [1:0]    gap_q;
  logic [1:0]    gap_d;
  logic          pend_q;
  logic          pend_d;
  logic [AW-1:0] pbase_q;
  logic [AW-1:0] pbase_d;
  logic [4:0]    pcnt_q;
  logic [4:0]    pcnt_d;
  logic [4:0]    ptgt_q;
  logic [4:0]    ptgt_d;
  logic [31:0]   data_q;
  logic          rdy_q;
  logic [AW-1:0] maddr_q;

  // Configuration decode
  wire           sync_w  = ~cfg_q[RS_BIT];
  wire [4:0]     xlat_w  = brc_xlat(cfg_q[XL_HI:XL_LO]);
  wire [1:0]     ylat_w  = cfg_q[YL_BIT] ? YL_TWO : YL_ONE;
  wire           early_w = cfg_q[RT_BIT];
  wire           seq_w   = cfg_q[BO_BIT];
  wire           rise_w  = cfg_q[CK_BIT];
  wire           latch_w = cfg_q[AT_BIT];
  wire [2:0]     blc_w   = cfg_q[BL_HI:BL_LO];
  wire           cont_w  = (blc_w == BL_CONT);
  wire [3:0]     len_w   = brc_blen(blc_w);
  wire [2:0]     omask_w = 3'(len_w - 4'h1);
  wire           pipe_ok_w = (blc_w == BL_4) | (blc_w == BL_8);

  // Valid edge of the burst clock, chosen by the edge bit
  wire           edge_w  = rise_w ? (lnk.burst_clk & ~k_q)
                                  : (~lnk.burst_clk & k_q);
  wire           ev_w    = edge_w & sync_w & ~lnk.ce_n;
  wire           cap_w   = ev_w & ~lnk.lat_n;

  // Start address in units: words, or double-words in x32
  wire [AW-1:0]  ua_w    = lnk.word32 ? {1'b0, lnk.addr[AW-1:1]}
                                      : lnk.addr;
  wire           unal_w  = cont_w & (|ua_w[1:0]);
  wire [4:0]     ctgt_w  = unal_w ? 5'(xlat_w + UNALIGN_EDGES)
                                  : xlat_w;

  // Burst order within the aligned block
  wire [2:0]     soff_w  = base_q[2:0];
  wire [2:0]     seqo_w  = 3'(soff_w + step_q[2:0]) & omask_w;
  wire [2:0]     into_w  = (soff_w ^ step_q[2:0]) & omask_w;
  wire [2:0]     off_w   = seq_w ? seqo_w : into_w;
  wire [AW-1:0]  fix_w   = (base_q & ~AW'(omask_w)) | AW'(off_w);
  wire [AW-1:0]  cua_w   = AW'(base_q + step_q);
  wire [AW-1:0]  top_w   = lnk.word32 ? {1'b0, {(AW-1){1'b1}}}
                                      : {AW{1'b1}};
  wire [AW-1:0]  nxt_w   = (cont_w ? cua_w : fix_w) & top_w;

  // When the next datum is due
  wire [4:0]     cnt1_w  = 5'(cnt_q + 5'h01);
  wire [1:0]     gap1_w  = (gap_q == YL_TWO) ? YL_TWO
                                             : 2'(gap_q + 2'h1);
  wire           wdue_w  = (st_q == ST_WAIT) & (cnt1_w >= tgt_q);
  wire           ddue_w  = (st_q == ST_DATA) & ~lnk.adv_n
                         & (gap1_w >= ylat_w);
  wire           due_w   = ev_w & (wdue_w | ddue_w);
  wire           last_w  = due_w & ~cont_w
                         & (4'(step_q[3:0] + 4'h1) == len_w);
  wire           pipe_w  = cap_w & (st_q != ST_IDLE) & pipe_ok_w
                         & ~last_w;

  // Sequencer next state
  always_comb begin
    st_d    = st_q;
    base_d  = base_q;
    step_d  = step_q;
    cnt_d   = cnt_q;
    tgt_d   = tgt_q;
    gap_d   = gap_q;
    pend_d  = pend_q;
    pbase_d = pbase_q;
    pcnt_d  = pcnt_q;
    ptgt_d  = ptgt_q;
    if (!sync_w || lnk.ce_n) begin
      st_d   = ST_IDLE;
      pend_d = 1'b0;
    end else if (ev_w) begin
      cnt_d = cnt1_w;
      gap_d = gap1_w;
      if (pend_q) begin
        pcnt_d = 5'(pcnt_q + 5'h01);
      end
      // Step moves only with a presented datum
      if (due_w) begin
        step_d = AW'(step_q + 1'b1);
        gap_d  = 2'h0;
        st_d   = ST_DATA;
      end
      // End of a fixed burst hands over to a queued one
      if (last_w) begin
        st_d   = pend_q ? ST_WAIT : ST_IDLE;
        base_d = pbase_q;
        step_d = '0;
        cnt_d  = 5'(pcnt_q + 5'h01);
        tgt_d  = ptgt_q;
        pend_d = 1'b0;
      end
      if (pipe_w) begin
        pend_d  = 1'b1;
        pbase_d = ua_w;
        pcnt_d  = 5'h00;
        ptgt_d  = ctgt_w;
      end else if (cap_w) begin
        st_d   = ST_WAIT;
        base_d = ua_w;
        step_d = '0;
        cnt_d  = 5'h00;
        tgt_d  = ctgt_w;
        pend_d = 1'b0;
      end
    end
  end

  // Early ready predicts the following valid edge
  wire           ndue_w  = ((st_d == ST_WAIT)
                            & (5'(cnt_d + 5'h01) >= tgt_d))
                         | ((st_d == ST_DATA) & ~lnk.adv_n
                            & ((3'(gap_d) + 3'h1) >= 3'(ylat_w)));
  wire           rnext_w = early_w ? ndue_w : due_w;
  wire [31:0]    rd_w    = lnk.word32 ? mem_rdata_i
                                      : {16'h0000, mem_rdata_i[15:0]};

  // Configuration register; holds until rewritten or reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg_q <= CFG_RESET;
    end else if (lnk.cfg_we) begin
      cfg_q <= lnk.cfg_data;
    end
  end

  // Sequencer state and previous clock level
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q    <= ST_IDLE;
      k_q     <= 1'b0;
      base_q  <= '0;
      step_q  <= '0;
      cnt_q   <= 5'h00;
      tgt_q   <= 5'h00;
      gap_q   <= 2'h0;
      pend_q  <= 1'b0;
      pbase_q <= '0;
      pcnt_q  <= 5'h00;
      ptgt_q  <= 5'h00;
    end else begin
      st_q    <= st_d;
      k_q     <= lnk.burst_clk;
      base_q  <= base_d;
      step_q  <= step_d;
      cnt_q   <= cnt_d;
      tgt_q   <= tgt_d;
      gap_q   <= gap_d;
      pend_q  <= pend_d;
      pbase_q <= pbase_d;
      pcnt_q  <= pcnt_d;
      ptgt_q  <= ptgt_d;
    end
  end

  // Output path; array address leads the datum by a cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      data_q  <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      maddr_q <= '0;
    end else if (sync_w) begin
      maddr_q <= nxt_w;
      if (due_w) begin
        data_q <= rd_w;
      end
      if (lnk.ce_n) begin
        rdy_q <= 1'b0;
      end else if (ev_w) begin
        rdy_q <= rnext_w;
      end
    end else begin
      // Latch mode freezes the address while latch enable is high
      if (!latch_w || !lnk.lat_n) begin
        maddr_q <= ua_w;
      end
      data_q <= rd_w;
      rdy_q  <= 1'b1;
    end
  end

  assign lnk.rdata  = data_q;
  assign lnk.ready  = rdy_q;
  assign mem_addr_o = maddr_q;
  assign cfg_o      = cfg_q;

endmodule

/* rtl/brc_host.sv */
// Host end: burst controller driving the link from a register port.
// Assumes DIV of at least two so ready settles between edges.
`timescale 1ns/10ps
module brc_host
  import brc_pkg::*;
#(
  parameter int AW  = 22,
  parameter int DIV = 2
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // Link to the flash end
  brc_if.host                lnk,
  // Software register port
  input  wire logic [3:0]    reg_addr_i,
  input  wire logic [31:0]   reg_wdata_i,
  input  wire logic          reg_we_i,
  input  wire logic          reg_re_i,
  output logic [31:0]        reg_rdata_o
);

  brc_hstate_t   st_q;
  logic [15:0]   cfg_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] next_q;
  logic [7:0]    words_q;
  logic [7:0]    cnt_q;
  logic [2:0]    ctrl_q;
  logic [31:0]   data_q;
  logic [31:0]   rdata_q;
  logic [7:0]    div_q;
  logic          k_q;
  logic          hev_q;
  logic          ce_n_q;
  logic          lat_n_q;
  logic          adv_n_q;
  logic          cfgwe_q;
  logic          plp_q;
  logic          pll_q;
  logic [AW-1:0] oaddr_q;

  // Register decode and burst clock divider
  wire        wr_ctrl_w = reg_we_i & (reg_addr_i == HR_CTRL);
  wire        start_w   = wr_ctrl_w & reg_wdata_i[HC_START];
  wire        tick_w    = (div_q == 8'(DIV - 1));
  wire        hev_w     = tick_w & ((~k_q) == cfg_q[CK_BIT]);
  wire        take_w    = hev_w & lnk.ready & (st_q == H_RUN);
  wire [7:0]  cnt1_w    = 8'(cnt_q + 8'h01);
  wire [31:0] stat_w    = {23'h000000, (st_q != H_IDLE), cnt_q};
  wire [31:0] mux_w     = (reg_addr_i == HR_CFG)   ? {16'h0000, cfg_q} :
                          (reg_addr_i == HR_ADDR)  ? 32'(addr_q) :
                          (reg_addr_i == HR_NEXT)  ? 32'(next_q) :
                          (reg_addr_i == HR_WORDS) ? {24'h000000, words_q} :
                          (reg_addr_i == HR_STAT)  ? stat_w :
                          (reg_addr_i == HR_DATA)  ? data_q :
                          (reg_addr_i == HR_CTRL)  ? {28'h0000000, ctrl_q,
                                                      1'b0} : 32'h0;

  // Software registers and read answer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg_q   <= CFG_RESET;
      addr_q  <= '0;
      next_q  <= '0;
      words_q <= 8'h00;
      ctrl_q  <= 3'h0;
      cfgwe_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      cfgwe_q <= reg_we_i & (reg_addr_i == HR_CFG);
      rdata_q <= reg_re_i ? mux_w : 32'h0;
      if (reg_we_i && reg_addr_i == HR_CFG) cfg_q <= reg_wdata_i[15:0];
      if (reg_we_i && reg_addr_i == HR_ADDR) addr_q <= reg_wdata_i[AW-1:0];
      if (reg_we_i && reg_addr_i == HR_NEXT) next_q <= reg_wdata_i[AW-1:0];
      if (reg_we_i && reg_addr_i == HR_WORDS) words_q <= reg_wdata_i[7:0];
      if (wr_ctrl_w) ctrl_q <= reg_wdata_i[HC_PIPE:HC_X32];
    end
  end

  // Burst clock runs free from the divider
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_q <= 8'h00;
      k_q   <= 1'b0;
      hev_q <= 1'b0;
    end else begin
      div_q <= tick_w ? 8'h00 : 8'(div_q + 8'h01);
      k_q   <= tick_w ? ~k_q : k_q;
      hev_q <= hev_w;
    end
  end

  // Burst sequence: latch, collect words, optional relatch
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q    <= H_IDLE;
      ce_n_q  <= 1'b1;
      lat_n_q <= 1'b1;
      adv_n_q <= 1'b1;
      cnt_q   <= 8'h00;
      data_q  <= 32'h0;
      plp_q   <= 1'b0;
      pll_q   <= 1'b0;
      oaddr_q <= '0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (start_w) begin
            st_q    <= H_ARM;
            ce_n_q  <= 1'b0;
            lat_n_q <= 1'b0;
            oaddr_q <= addr_q;
            cnt_q   <= 8'h00;
            plp_q   <= reg_wdata_i[HC_PIPE];
          end
        end
        H_ARM: begin
          if (hev_q) begin
            st_q    <= H_RUN;
            lat_n_q <= 1'b1;
            adv_n_q <= ctrl_q[HC_HOLD-1];
          end
        end
        H_RUN: begin
          adv_n_q <= ctrl_q[HC_HOLD-1];
          // Relatch right after capture, well before the last datum
          if (hev_q && plp_q) begin
            lat_n_q <= 1'b0;
            oaddr_q <= next_q;
            plp_q   <= 1'b0;
            pll_q   <= 1'b1;
          end else if (hev_q && pll_q) begin
            lat_n_q <= 1'b1;
            pll_q   <= 1'b0;
          end
          if (take_w) begin
            data_q <= lnk.rdata;
            cnt_q  <= cnt1_w;
            if (cnt1_w == words_q) begin
              st_q    <= H_IDLE;
              ce_n_q  <= 1'b1;
              adv_n_q <= 1'b1;
              lat_n_q <= 1'b1;
              plp_q   <= 1'b0;
              pll_q   <= 1'b0;
            end
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign lnk.burst_clk = k_q;
  assign lnk.ce_n      = ce_n_q;
  assign lnk.lat_n     = lat_n_q;
  assign lnk.adv_n     = adv_n_q;
  assign lnk.addr      = oaddr_q;
  assign lnk.word32    = ctrl_q[HC_X32-1];
  assign lnk.cfg_we    = cfgwe_q;
  assign lnk.cfg_data  = cfg_q;
  assign reg_rdata_o   = rdata_q;

endmodule

/* verif/brc_link_props.sv */
// Checker for the burst read link between host and flash ends.
// Assumes it sits beside the link and sees every link signal.
`timescale 1ns/10ps
module brc_link_props
  import brc_pkg::*;
#(
  parameter int AW = 22
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          nrst_i,
  // Link signals
  input wire logic          burst_clk,
  input wire logic          ce_n,
  input wire logic          lat_n,
  input wire logic          adv_n,
  input wire logic [AW-1:0] addr,
  input wire logic          word32,
  input wire logic          cfg_we,
  input wire logic [15:0]   cfg_data,
  input wire logic [31:0]   rdata,
  input wire logic          ready
);
  logic [15:0] cfg_q;
  logic        bck_q, act_q, una_q, advh_q;
  logic [5:0]  ecnt_q, gap_q;
  logic [4:0]  nd_q;

  // Decoded view of the shadowed configuration
  wire       vl   = cfg_q[CK_BIT];
  wire       ve   = (burst_clk == vl) && (bck_q != vl);
  wire       cap  = ve && !ce_n && !lat_n;
  wire       sync = !cfg_q[RS_BIT];
  wire       una  = word32 ? (addr[2:1] != 2'b00) : (addr[1:0] != 2'b00);
  wire [2:0] bl   = cfg_q[BL_HI:BL_LO];
  wire [3:0] xc   = cfg_q[XL_HI:XL_LO];
  wire [5:0] xl   = (xc inside {[4'h2:4'h6]}) ? {2'b0, xc} + 6'h05 :
                    (xc inside {[4'h9:4'hB]}) ? {2'b0, xc} + 6'h03 : 6'h10;
  wire [4:0] len  = bl == BL_1 ? 5'h01 : bl == BL_2 ? 5'h02 :
                    bl == BL_4 ? 5'h04 : bl == BL_8 ? 5'h08 : 5'h00;
  wire [5:0] flat = xl + {5'h00, !cfg_q[RT_BIT]} +
                    ((len == 5'h00 && una_q) ? 6'h04 : 6'h00);
  wire [5:0] yl   = cfg_q[YL_BIT] ? 6'h02 : 6'h01;

  // Shadow config; write lands on the same edge as in the device
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg_q <= CFG_RESET;
      bck_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      bck_q <= burst_clk;
      if (cfg_we) cfg_q <= cfg_data;
      if (cap) act_q <= 1'b1;
      else if (ce_n) act_q <= 1'b0;
    end
  end

  // Edges since capture, data seen, spacing since the last datum
  always_ff @(posedge clk_i) begin
    if (cap) begin
      ecnt_q <= 6'h01;
      nd_q   <= 5'h00;
      una_q  <= una;
    end else if (ve) begin
      ecnt_q <= ecnt_q + 6'h01;
      nd_q   <= nd_q + {4'h0, act_q && ready};
      gap_q  <= ready ? 6'h01 : gap_q + 6'h01;
      advh_q <= ready ? adv_n : (advh_q || adv_n);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_async_ready: assert property (
    $past(nrst_i) && !sync && $past(cfg_q[RS_BIT]) |-> ready)
    else $error("ready low in asynchronous mode");
  a_idle_no_ready: assert property (
    sync && $past(sync) && ce_n && $past(ce_n) |-> !ready)
    else $error("ready high while deselected");
  a_first_latency: assert property (
    ve && sync && lat_n && act_q && nd_q == 5'h00 && ecnt_q <= flat
    |-> ready == (ecnt_q == flat))
    else $error("first datum at wrong edge");
  a_next_spacing: assert property (
    ve && sync && act_q && nd_q != 5'h00 && nd_q != len && !advh_q &&
    gap_q <= yl |-> ready == (gap_q == yl))
    else $error("next datum spacing wrong");
  a_burst_end: assert property (
    ve && sync && len != 5'h00 && nd_q == len |-> !ready)
    else $error("datum beyond burst length");
  a_edge_only: assert property (
    sync && $past(sync, 3) && $past(nrst_i, 3) && !$past(ve) &&
    !$past(ve, 2) |-> $stable(rdata))
    else $error("data changed off the valid edge");
  a_cont_seq: assert property (
    cap && sync && len == 5'h00 |-> cfg_q[BO_BIT])
    else $error("continuous burst not sequential");
  a_x32_len: assert property (
    cap && sync && word32 |-> bl != BL_8)
    else $error("length eight in 32-bit mode");
endmodule

/* verif/burst_read_config_tb_top.sv */
// Bench for the burst read link: register port in, link data out.
// Assumes an array model that answers with its own unit address.
`timescale 1ns/10ps
module burst_read_config_tb_top
  import brc_pkg::*;
;
  localparam logic [3:0] XC [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                                    4'h9, 4'hA, 4'hB, 4'hC};
  localparam int         XV [9] = '{7, 8, 9, 10, 11, 12, 13, 14, 16};
  logic        clk_i, nrst_i, we, re, bck, bce;
  logic [3:0]  ra;
  logic [31:0] wd, rd, mdat;
  logic [21:0] maddr;
  logic [15:0] cfg;
  int          mismatches, n_tests, cyc, ecnt, first;
  logic [31:0] got[$];

  // Both ends over one link, checker beside it
  brc_if #(.AW(22)) lnk ();
  brc_device #(.AW(22)) brc_device_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .lnk(lnk), .mem_addr_o(maddr), .mem_rdata_i(mdat), .cfg_o(cfg));
  brc_host #(.AW(22), .DIV(2)) brc_host_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .lnk(lnk), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rd));
  brc_link_props #(.AW(22)) brc_link_props_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .burst_clk(lnk.burst_clk), .ce_n(lnk.ce_n),
    .lat_n(lnk.lat_n), .adv_n(lnk.adv_n), .addr(lnk.addr),
    .word32(lnk.word32), .cfg_we(lnk.cfg_we), .cfg_data(lnk.cfg_data),
    .rdata(lnk.rdata), .ready(lnk.ready));
  assign mdat = {~maddr[15:0], maddr[15:0]};
  wire ve = (lnk.burst_clk == cfg[CK_BIT]) && (bck != cfg[CK_BIT]);

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Collect data flagged ready at valid edges; time the first one
  // Host lifts chip enable right after its last take, so use last level
  always @(posedge clk_i) begin
    bck <= lnk.burst_clk;
    bce <= lnk.ce_n;
    cyc <= cyc + 1;
    if (ve && !lnk.ce_n && !lnk.lat_n) ecnt <= 1;
    else if (ve) ecnt <= ecnt + 1;
    if (ve && !bce && lnk.ready && !cfg[RS_BIT]) begin
      if (got.size() == 0) first <= ecnt;
      got.push_back(lnk.rdata);
    end
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    re <= 1'b1;
    ra <= a;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rd;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [15:0] cf(input logic [3:0] x, input logic y,
      input logic o, input logic k, input logic [2:0] l);
    return {1'b0, x, 1'b0, y, 1'b0, o, k, 3'b000, l};
  endfunction

  // Expected datum: unit address of step i, wrapped in its block
  function automatic logic [31:0] ex(input logic [15:0] c,
      input logic [21:0] a, input logic x, input int i);
    int          l;
    logic [21:0] u, m;
    case (c[BL_HI:BL_LO])
      BL_1:    l = 1;
      BL_2:    l = 2;
      BL_4:    l = 4;
      BL_8:    l = 8;
      default: l = 0;
    endcase
    u = x ? {1'b0, a[21:1]} : a;
    m = 22'(l - 1);
    if (l == 0) u = (u + 22'(i)) & (x ? 22'h1FFFFF : 22'h3FFFFF);
    else if (c[BO_BIT]) u = (u & ~m) | ((u + 22'(i)) & m);
    else u = (u & ~m) | ((u ^ 22'(i)) & m);
    return x ? {~u[15:0], u[15:0]} : {16'h0, u[15:0]};
  endfunction

  // One burst through the host; hold keeps advance high a while
  task automatic bu(input logic [15:0] c, input logic [21:0] a,
                    input logic x, input logic h, input int n);
    logic [31:0] v;
    int          k;
    got.delete();
    wr(HR_CFG, {16'h0, c});
    wr(HR_ADDR, {10'h0, a});
    wr(HR_WORDS, 32'(n));
    wr(HR_CTRL, {28'h0, 1'b0, h, x, 1'b1});
    if (h) begin
      repeat (200) @(posedge clk_i);
      chk(32'(got.size() < 2), 32'h1);
      wr(HR_CTRL, {30'h0, x, 1'b0});
    end
    repeat (2) @(posedge clk_i);
    v = 32'h100;
    for (k = 0; k < 3000 && v[8] !== 1'b0; k++) rdr(HR_STAT, v);
    chk(v, 32'(n));
    for (k = 0; k < n; k++) chk(got[k], ex(c, a, x, k));
    rdr(HR_DATA, v);
    chk(v, ex(c, a, x, n - 1));
    $display("burst cfg %h addr %h done", c, a);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    logic [31:0] v;
    nrst_i = 1'b0;
    we = 1'b0;
    re = 1'b0;
    ra = 4'h0;
    wd = 32'h0;
    bck = 1'b0;
    bce = 1'b1;
    cyc = 0;
    ecnt = 0;
    first = 0;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({16'h0, cfg}, {16'h0, CFG_RESET});
    chk({31'h0, lnk.ready}, 32'h1);
    rdr(4'hF, v);
    chk(v, 32'h0);
    // Every latency code, edge polarity alternating; 7 needs continuous
    for (int i = 0; i < 9; i++) begin
      bu(cf(XC[i], 1'b0, 1'b1, i[0], i == 0 ? BL_CONT : BL_1),
         22'h000100, 1'b0, 1'b0, 1);
      chk(32'(first), 32'(XV[i] + 1));
    end
    // Early ready: first flag one edge sooner, host stops there
    got.delete();
    wr(HR_CFG, {16'h0, cf(XL_9, 1'b0, 1'b1, 1'b1, BL_1) | 16'h0100});
    wr(HR_WORDS, 32'h00000001);
    wr(HR_CTRL, 32'h00000001);
    repeat (150) @(posedge clk_i);
    chk(32'(first), 32'h00000009);
    bu(cf(XL_8, 1'b0, 1'b1, 1'b1, BL_4), 22'h000201, 1'b0, 1'b0, 4);
    bu(cf(XL_9, 1'b1, 1'b0, 1'b0, BL_8), 22'h000305, 1'b0, 1'b0, 8);
    bu(cf(XL_12, 1'b0, 1'b0, 1'b1, BL_4), 22'h000407, 1'b1, 1'b0, 4);
    bu(cf(XL_8, 1'b0, 1'b1, 1'b0, BL_2), 22'h000011, 1'b0, 1'b0, 2);
    bu(cf(XL_7, 1'b0, 1'b1, 1'b1, BL_CONT), 22'h000022, 1'b0, 1'b0, 6);
    bu(cf(XL_10, 1'b1, 1'b1, 1'b0, BL_CONT), 22'h3FFFFE, 1'b0, 1'b0, 5);
    bu(cf(XL_8, 1'b0, 1'b1, 1'b1, BL_CONT), 22'h000040, 1'b0, 1'b1, 4);
    wr(HR_CFG, 32'h00008008);
    repeat (3) @(posedge clk_i);
    #1;
    chk({16'h0, cfg}, 32'h00008008);
    chk({31'h0, lnk.ready}, 32'h1);
    // Latch-controlled asynchronous read through the host
    wr(HR_ADDR, 32'h00000123);
    wr(HR_WORDS, 32'h00000001);
    wr(HR_CTRL, 32'h00000001);
    repeat (20) @(posedge clk_i);
    rdr(HR_DATA, v);
    chk(v, 32'h00000123);
    end_of_test();
  end
endmodule
